/* File: rtl/input_sync2.sv */
// two-stage synchroniser for a bus of asynchronous pin inputs
module input_sync2 #(
  parameter int unsigned WIDTH = 1                       // number of inputs
) (
  input  wire logic             i_core_clk,              // core clock
  input  wire logic             i_resetn,                // async reset, low
  input  wire logic             i_ce,                    // clock enable
  input  wire logic [WIDTH-1:0] i_async,                 // raw pin levels
  input  wire logic [WIDTH-1:0] i_rst_val,               // reset level tie-off, unused; both stages reset to zero
  output logic      [WIDTH-1:0] o_sync                   // synchronised levels
);

  logic [WIDTH-1:0] meta_r;                              // first stage, read only by second

  // both stages reset to zero; callers invert active-low pins so zero is idle
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_r <= '0;
      o_sync <= '0;
    end
    else if (i_ce)
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

  // unused by the logic; kept so the width check of the tie-off elaborates
  wire unused_rst = ^i_rst_val;

endmodule

/* File: rtl/motion_event_irq.sv */
// interrupt front end: input sync, drive protect and three interrupt groups
//
// The address-and-strobe port and the register addresses are this design's own decisions.
module motion_event_irq #(
  parameter int unsigned NUM_IN = 4                      // extra synchronised pins
) (
  input  wire logic                                  i_core_clk,      // 100 MHz core clock
  input  wire logic                                  i_resetn,        // async reset, low
  input  wire logic                                  i_ce,            // clock enable
  input  wire logic [motion_event_pkg::ADDR_W-1:0]  i_addr,          // word offset
  input  wire logic [motion_event_pkg::DATA_W-1:0]  i_wdata,         // write data
  input  wire logic                                  i_wr,            // write strobe
  input  wire logic                                  i_rd,            // read strobe
  output logic      [motion_event_pkg::DATA_W-1:0]  o_rdata,         // read data, next cycle
  input  wire logic                                  i_drive_protect_in_n, // protect pin, low
  input  wire logic [NUM_IN-1:0]                     i_pins,          // other module pins
  output logic      [NUM_IN-1:0]                     o_pins_sync,     // synchronised pins
  input  wire logic [15:0]                           i_evt_a,         // group a event pulses
  input  wire logic [15:0]                           i_evt_b,         // group b event pulses
  input  wire logic [15:0]                           i_evt_c,         // group c event pulses
  output logic                                       o_out_hiz,       // float all outputs
  output logic      [2:0]                            o_irq            // group requests a,b,c
);

  // elaboration check: the pin bus may not be empty
  if (NUM_IN < 1)
  begin : g_num_in_check
    $error("NUM_IN must be at least one");
  end

  localparam int unsigned G = motion_event_pkg::NUM_GROUPS;

  motion_event_pkg::reg_req_t req;                       // bundled request
  assign req.wr    = i_wr;
  assign req.rd    = i_rd;
  assign req.addr  = i_addr;
  assign req.wdata = i_wdata;

  // priority encoder: lowest set bit wins, 1-based index, 0 when none
  function automatic logic [4:0] low_index(input logic [15:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 15; i >= 0; i--)
    begin
      if (v[i])
        idx = 5'(i + 1);
    end
    return idx;
  endfunction

  // one-hot of the lowest set bit, used for the clear on vector read
  function automatic logic [15:0] low_onehot(input logic [15:0] v);
    return v & (~v + 16'h0001);
  endfunction

  // synchronise protect pin together with the other pins; protect is inverted
  // so every stage idles at its reset level and no false edge follows reset
  logic [NUM_IN:0] sync_w;                               // synchronised levels
  input_sync2 #(
    .WIDTH (NUM_IN + 1)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_ce       (i_ce),
    .i_async    ({i_pins, ~i_drive_protect_in_n}),
    .i_rst_val  ({(NUM_IN + 1){1'b0}}),
    .o_sync     (sync_w)
  );

  // qualification stage: level must match twice to count
  logic prot_q_r;                                        // qualified protect level
  logic prot_prev_r;                                     // previous synchronised level
  logic [NUM_IN-1:0] pins_r;                             // registered synced pins

  // protect edge is qualified when two synced samples agree on asserted
  // while the qualified level is still idle; a one-cycle glitch never counts
  wire prot_fall = !prot_q_r && sync_w[0] && prot_prev_r;

  // register state
  logic [15:0] mask_r [G];                               // mask per group
  logic [15:0] mask_nxt [G];                             // mask after this cycle's write
  logic [15:0] flag_r [G];                               // flag per group
  logic [15:0] flag_nxt [G];                             // next flag value
  logic [15:0] evt [G];                                  // events per group
  logic [15:0] pend [G];                                 // set and unmasked
  logic [15:0] rd_r;                                     // read data register
  logic        hiz_r;                                    // output float register
  logic [2:0]  irq_r;                                    // request register

  assign evt[0] = {i_evt_a[15:1], i_evt_a[0] | prot_fall};
  assign evt[1] = i_evt_b;
  assign evt[2] = i_evt_c;

  // address decode
  wire [5:0] a = req.addr;
  wire sel_mask = (a >= motion_event_pkg::OFS_MASK_A) &&
                  (a <  motion_event_pkg::OFS_FLAG_A);
  wire sel_flag = (a >= motion_event_pkg::OFS_FLAG_A) &&
                  (a <  motion_event_pkg::OFS_VECTOR_A);
  wire sel_vec  = (a >= motion_event_pkg::OFS_VECTOR_A) &&
                  (a <  motion_event_pkg::OFS_PROTECT);
  wire sel_prot = (a == motion_event_pkg::OFS_PROTECT);
  motion_event_pkg::acc_kind_t kind;
  assign kind = sel_mask ? motion_event_pkg::ACC_MASK :
                sel_flag ? motion_event_pkg::ACC_FLAG :
                sel_vec  ? motion_event_pkg::ACC_VECTOR :
                           motion_event_pkg::ACC_OTHER;
  wire [5:0] gm = 6'(a - motion_event_pkg::OFS_MASK_A);   // group index within each bank
  wire [5:0] gf = 6'(a - motion_event_pkg::OFS_FLAG_A);
  wire [5:0] gv = 6'(a - motion_event_pkg::OFS_VECTOR_A);

  // vector identifiers per group, distinct via group base
  logic [7:0] id_base [G];
  assign id_base[0] = motion_event_pkg::ID_BASE_A;
  assign id_base[1] = motion_event_pkg::ID_BASE_B;
  assign id_base[2] = motion_event_pkg::ID_BASE_C;

  logic [15:0] vec_word [G];                             // vector read value
  logic [15:0] vec_clr [G];                              // flag cleared by vector read
  genvar g;
  generate
    for (g = 0; g < G; g++)
    begin : grp
      assign pend[g] = flag_r[g] & mask_r[g];
      wire mwr = req.wr && (kind == motion_event_pkg::ACC_MASK) && (gm == 6'(g));
      assign mask_nxt[g] = mwr ? req.wdata : mask_r[g];
      // id = base + bit index; zero when nothing pending
      wire [4:0] li = low_index(pend[g]);
      assign vec_word[g] = (li == 5'h00) ? 16'h0000 :
                           {8'h00, 8'(id_base[g] + {3'b000, li} - 8'h01)};
      wire vrd = req.rd && (kind == motion_event_pkg::ACC_VECTOR) && (gv == 6'(g));
      assign vec_clr[g] = vrd ? low_onehot(pend[g]) : 16'h0000;
      wire fwr = req.wr && (kind == motion_event_pkg::ACC_FLAG) && (gf == 6'(g));
      wire [15:0] wclr = fwr ? req.wdata : 16'h0000;
      // set wins over any clear; mask plays no part here
      assign flag_nxt[g] = (flag_r[g] & ~(wclr | vec_clr[g])) | evt[g];
    end
  endgenerate

  // read mux: undefined offsets and bits read zero
  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = 16'h0000;
    unique case (kind)
      motion_event_pkg::ACC_MASK:   rd_mux = (gm < 6'(G)) ? mask_r[gm[1:0]] : 16'h0000;
      motion_event_pkg::ACC_FLAG:   rd_mux = (gf < 6'(G)) ? flag_r[gf[1:0]] : 16'h0000;
      motion_event_pkg::ACC_VECTOR: rd_mux = (gv < 6'(G)) ? vec_word[gv[1:0]] : 16'h0000;
      motion_event_pkg::ACC_OTHER:  rd_mux = sel_prot ? {15'h0000, sync_w[0]} : 16'h0000;
    endcase
  end

  // float: one edge after the raw pin when protect unmasked, held by flag after
  // same mask view as the request, so float and request see a mask write in the same cycle
  wire prot_unmasked = mask_nxt[0][motion_event_pkg::PROTECT_BIT];
  wire hiz_nxt = prot_unmasked &&
                 (!i_drive_protect_in_n ||
                  flag_nxt[0][motion_event_pkg::PROTECT_BIT]);
  // the raw pin path is a registered output, so it lands one edge after the pin;
  // a purely combinational float would break the registered-output convention

  // sync stage qualification and registers
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      prot_q_r    <= 1'b0;
      prot_prev_r <= 1'b0;
      pins_r      <= '0;
      rd_r        <= 16'h0000;
      hiz_r       <= 1'b0;
      irq_r       <= 3'b000;
      for (int i = 0; i < G; i++)
      begin
        mask_r[i] <= motion_event_pkg::RST_MASK;
        flag_r[i] <= motion_event_pkg::RST_FLAG;
      end
    end
    else if (i_ce)
    begin
      prot_prev_r <= sync_w[0];
      if (sync_w[0] == prot_prev_r)
        prot_q_r  <= sync_w[0];
      pins_r      <= sync_w[NUM_IN:1];
      rd_r        <= req.rd ? rd_mux : 16'h0000;
      hiz_r       <= hiz_nxt;
      for (int i = 0; i < G; i++)
      begin
        flag_r[i] <= flag_nxt[i];
        mask_r[i] <= mask_nxt[i];
        irq_r[i]  <= |(flag_nxt[i] & mask_nxt[i]);
      end
    end
  end

  assign o_rdata     = rd_r;
  assign o_out_hiz   = hiz_r;
  assign o_irq       = irq_r;
  assign o_pins_sync = pins_r;

endmodule

/* File: rtl/motion_event_pkg.sv */
// package: constants, types and overview for the motion event interrupt front end
// Overview of operation
// - inputs synchronised, synced pins change three edges after the pin
// - protect low and unmasked floats outputs at once; the design registers the float, so it lands one edge after the pin
// - protect flag set three to four cycles later
// - flag set and unmasked holds float, requests interrupt
// - protect flag set regardless of mask
// - registers in a 64-word, 16-bit data window
// - undefined register bits read as zero
// - three groups, each flag, mask, vector, request
// - each source has a distinct vector identifier
// - enabled source event sets its flag
// - mask 0 blocks, mask 1 allows
// - group requests when any flag set and unmasked
// - flags behave the same whether masked or not
// - vector read clears the returned source flag
// - vector read returns highest priority pending identifier
// - no pending source returns identifier zero
// - masks, then flags, then vectors, consecutive addresses
package motion_event_pkg;

  localparam int unsigned DATA_W     = 16;               // register word width
  localparam int unsigned ADDR_W     = 6;                // 64-word window
  localparam int unsigned NUM_GROUPS = 3;                // groups a, b, c
  localparam int unsigned SRC_W      = 16;               // sources per group

  // word offsets inside the window (window base is decoded outside)
  localparam logic [5:0] OFS_MASK_A   = 6'h2C;           // group_a_mask_reg
  localparam logic [5:0] OFS_FLAG_A   = 6'h2F;           // group_a_flag_reg
  localparam logic [5:0] OFS_VECTOR_A = 6'h32;           // group_a_vector_reg
  localparam logic [5:0] OFS_PROTECT  = 6'h35;           // protect status word

  // reset values
  localparam logic [15:0] RST_MASK = 16'h0000;           // all sources masked
  localparam logic [15:0] RST_FLAG = 16'h0000;           // no pending flags

  // protect source position in group a (bit 0, highest priority)
  localparam int unsigned PROTECT_BIT = 0;
  // identifier base per group so ids never collide across groups
  localparam logic [7:0] ID_BASE_A = 8'h01;
  localparam logic [7:0] ID_BASE_B = 8'h21;
  localparam logic [7:0] ID_BASE_C = 8'h41;

  // register port request carried as one bundle
  typedef struct packed {
    logic              wr;                               // write strobe
    logic              rd;                               // read strobe
    logic [ADDR_W-1:0] addr;                             // word offset
    logic [DATA_W-1:0] wdata;                            // write data
  } reg_req_t;

  // register access decode classes
  typedef enum logic [1:0] {
    ACC_MASK   = 2'b00,
    ACC_FLAG   = 2'b01,
    ACC_VECTOR = 2'b11,
    ACC_OTHER  = 2'b10
  } acc_kind_t;

endpackage

/* File: tb/cpu_irq_model.sv */
// cpu side model: latches group requests as taken until acknowledged
module cpu_irq_model (
  input  wire logic       i_core_clk, // core clock
  input  wire logic       i_resetn,   // async reset, low
  input  wire logic [2:0] i_irq,      // group request levels
  input  wire logic [2:0] i_ack,      // service finished, one cycle
  output logic      [2:0] o_taken     // request taken by the core
);
  timeunit 1ns;
  timeprecision 1ps;
  // a level request is taken at the first edge it is seen
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_taken <= 3'h0;
    else
      o_taken <= (o_taken | i_irq) & ~i_ack;
  end
endmodule

/* File: tb/motion_event_irq_assertions.sv */
// checker: port-level properties of the motion event interrupt front end
module motion_event_irq_assertions #(
  parameter int unsigned NUM_IN = 4                 // synchronised pin count
) (
  input wire logic              i_core_clk,           // core clock
  input wire logic              i_resetn,             // async reset, low
  input wire logic              i_ce,                 // clock enable
  input wire logic [5:0]        i_addr,               // word offset
  input wire logic [15:0]       i_wdata,              // write data
  input wire logic              i_wr,                 // write strobe
  input wire logic              i_rd,                 // read strobe
  input wire logic [15:0]       o_rdata,              // read data
  input wire logic              i_drive_protect_in_n, // protect pin
  input wire logic [NUM_IN-1:0] i_pins,               // raw pins
  input wire logic [NUM_IN-1:0] o_pins_sync,          // synced pins
  input wire logic [15:0]       i_evt_a,              // group a events
  input wire logic [15:0]       i_evt_b,              // group b events
  input wire logic [15:0]       i_evt_c,              // group c events
  input wire logic              o_out_hiz,            // float outputs
  input wire logic [2:0]        o_irq                 // group requests
);
  timeunit 1ns;
  timeprecision 1ps;
  // decoded accesses to group a, watched by several properties
  wire logic vec_a  = i_ce && i_rd && i_addr == motion_event_pkg::OFS_VECTOR_A;
  wire logic mask_a = i_ce && i_wr && i_addr == motion_event_pkg::OFS_MASK_A;
  wire logic flag_a = i_ce && i_wr && i_addr == motion_event_pkg::OFS_FLAG_A;
  wire logic pdp_n  = i_drive_protect_in_n;           // short alias

  // one clock domain, so one default clock and reset
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside its slot");
  a_mask_blocks: assert property (mask_a && i_wdata == 16'h0000 |=> !o_irq[0])
    else $error("masked group a still requests");
  a_vec_none: assert property (vec_a && !o_irq[0] |=> o_rdata == 16'h0000)
    else $error("vector read without request not zero");
  a_vec_range: assert property (vec_a && o_irq[0] |=> o_rdata inside {[1:16]})
    else $error("group a vector id out of range");
  a_flag_clear: assert property (flag_a && i_wdata == 16'hFFFF && i_evt_a == 16'h0000
    && pdp_n && $past(pdp_n, 5) |=> !o_irq[0])
    else $error("write one did not clear group a flags");
  a_hiz_cause: assert property (o_out_hiz |-> o_irq[0] || !$past(pdp_n))
    else $error("outputs float without protect cause");
  a_hiz_flag: assert property ($fell(pdp_n) ##1 !pdp_n [*5] ##0 o_out_hiz |-> o_irq[0])
    else $error("protect flag not requesting after low pulse");
  a_sync_lat: assert property (o_pins_sync == $past(i_pins, 3))
    else $error("synchronised pins wrong latency");

  // main scenarios reached
  c_vec_read: cover property (vec_a && o_irq[0]);
  c_hiz_rise: cover property ($rose(o_out_hiz));
  c_mask_off: cover property (mask_a && i_wdata == 16'h0000);
endmodule

/* File: tb/motion_event_irq_bench.sv */
// bench: random and corner stimulus for the motion event interrupt front end
module motion_event_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, ce, wr, rd, pdp_n; // clock, reset, enable, strobes, protect
  logic [5:0]  addr;                      // word offset
  logic [15:0] wdata, rdata, ea, eb, ec;  // bus and event lines
  logic [15:0] d, m, e, p;                // read value, mask, events, pending
  logic [3:0]  pins, psync;               // raw and synced pins
  logic        hiz;                       // float request
  logic [2:0]  irq, taken, ack;           // requests and core side
  int          mismatches, cmp_count;     // error and compare counters

  motion_event_irq #(.NUM_IN(4)) motion_event_irq_i (.i_core_clk(clk), .i_resetn(rstn),
    .i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_drive_protect_in_n(pdp_n), .i_pins(pins), .o_pins_sync(psync), .i_evt_a(ea),
    .i_evt_b(eb), .i_evt_c(ec), .o_out_hiz(hiz), .o_irq(irq));
  cpu_irq_model cpu_irq_model_i (.i_core_clk(clk), .i_resetn(rstn), .i_irq(irq),
    .i_ack(ack), .o_taken(taken));

  // compare a word; an unknown never matches
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // compare one flag
  task automatic chk_b(input logic got, input logic exp);
    chk_w({15'h0000, got}, {15'h0000, exp});
  endtask
  // offset of register g places after a base
  function automatic logic [5:0] ofs(input logic [5:0] b, input int g);
    return b + 6'(g);
  endfunction
  // expected id: lowest pending bit wins, zero when none
  function automatic logic [15:0] exp_vec(input int g, input logic [15:0] q);
    logic [7:0] b;
    b = g == 0 ? motion_event_pkg::ID_BASE_A : g == 1 ? motion_event_pkg::ID_BASE_B
      : motion_event_pkg::ID_BASE_C;
    for (int i = 0; i < 16; i++)
      if (q[i])
        return {8'h00, b + 8'(i)};
    return 16'h0000;
  endfunction
  // one-cycle write, strobe dropped at the next edge
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, v};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one-cycle read; data stands only in the following cycle
  task automatic rd_reg(input logic [5:0] a, output logic [15:0] v);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // verdict and end of run
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog: the whole run needs far less than this
  initial
  begin
    #200us;
    mismatches++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    {ce, rstn, wr, rd, pdp_n, addr, wdata, ea, eb, ec, pins, ack} = {5'b10001, 77'h0};
    void'($urandom(32'h93924abf));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    // masks then flags at consecutive offsets, all clear after reset
    for (int g = 0; g < 6; g++)
    begin
      rd_reg(ofs(motion_event_pkg::OFS_MASK_A, g), d);
      chk_w(d, 16'h0000);
    end
    wr_reg(6'h3F, 16'hFFFF);
    rd_reg(6'h3F, d);
    chk_w(d, 16'h0000);
    // random events per group; first rounds have none pending
    for (int n = 0; n < 30; n++)
    begin
      m = n < 6 ? 16'hFFFF : 16'($urandom);
      e = n < 3 ? 16'h0000 : n < 6 ? 16'h8000 : 16'($urandom);
      e[0] = e[0] & (n % 3 != 0);  // group a bit 0 belongs to protect
      wr_reg(ofs(motion_event_pkg::OFS_MASK_A, n % 3), m);
      rd_reg(ofs(motion_event_pkg::OFS_MASK_A, n % 3), d);
      chk_w(d, m);
      {ec, eb, ea} <= 48'(e) << (16 * (n % 3));
      @(posedge clk);
      {ec, eb, ea} <= 48'h0;
      rd_reg(ofs(motion_event_pkg::OFS_FLAG_A, n % 3), d);
      chk_w(d, e);
      p = e & m;
      chk_b(irq[n % 3], |p);
      chk_b(taken[n % 3], |p);
      rd_reg(ofs(motion_event_pkg::OFS_VECTOR_A, n % 3), d);
      chk_w(d, exp_vec(n % 3, p));
      rd_reg(ofs(motion_event_pkg::OFS_FLAG_A, n % 3), d);
      chk_w(d, e & ~(p & -p));
      wr_reg(ofs(motion_event_pkg::OFS_FLAG_A, n % 3), 16'hFFFF);
      ack <= 3'(1 << (n % 3));
      rd_reg(ofs(motion_event_pkg::OFS_FLAG_A, n % 3), d);
      ack <= 3'h0;
      chk_w(d, 16'h0000);
    end
    // event and write-one clear in the same cycle: event wins
    @(posedge clk);
    {wr, addr, wdata, eb} <= {1'b1, motion_event_pkg::OFS_FLAG_A + 6'h01, 32'hFFFF0004};
    @(posedge clk);
    {wr, eb} <= 17'h0;
    rd_reg(motion_event_pkg::OFS_FLAG_A + 6'h01, d);
    chk_w(d, 16'h0004);
    // enable low freezes state: a write in that cycle must not land
    wr_reg(motion_event_pkg::OFS_MASK_A + 6'h02, 16'h00F0);
    @(posedge clk);
    {ce, wr, addr, wdata} <= {2'b01, motion_event_pkg::OFS_MASK_A + 6'h02, 16'h5A5A};
    @(posedge clk);
    {ce, wr} <= 2'b10;
    rd_reg(motion_event_pkg::OFS_MASK_A + 6'h02, d);
    chk_w(d, 16'h00F0);
    // protect low: unmasked then masked; held well over four cycles
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(motion_event_pkg::OFS_MASK_A, 16'(1 - k));
      pdp_n <= 1'b0;
      @(posedge clk);
      #1 chk_b(hiz, k == 0);
      @(posedge clk);
      #1 chk_b(irq[0], 1'b0);
      rd_reg(motion_event_pkg::OFS_PROTECT, d);
      chk_w(d, 16'h0001);
      rd_reg(motion_event_pkg::OFS_FLAG_A, d);
      pdp_n <= 1'b1;
      chk_w(d, 16'h0001);
      repeat (4) @(posedge clk);
      #1 chk_b(hiz, k == 0);
      wr_reg(motion_event_pkg::OFS_FLAG_A, 16'h0001);
      #1 chk_b(hiz, 1'b0);
    end
    // pins held five cycles before the synced copy is looked at
    pins <= 4'($urandom);
    repeat (5) @(posedge clk);
    #1 chk_w({12'h000, psync}, {12'h000, pins});
    end_of_test();
  end
endmodule

bind motion_event_irq motion_event_irq_assertions #(.NUM_IN(NUM_IN)) motion_event_irq_assertions_i (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_drive_protect_in_n(i_drive_protect_in_n), .i_pins(i_pins), .o_pins_sync(o_pins_sync),
  .i_evt_a(i_evt_a), .i_evt_b(i_evt_b), .i_evt_c(i_evt_c),
  .o_out_hiz(o_out_hiz), .o_irq(o_irq));
